// file: design/xbc_crossbar.sv
// slot crossbar: fifo, register slave and frame-rate routing engine
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none


module xbc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready,
    output logic [WIDTH-1:0] m_data,
    output logic m_valid,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic do_push;
    logic do_pop;

    assign s_ready = (count_reg != (AW+1)'(DEPTH));
    assign m_valid = (count_reg != '0);
    assign m_data = mem[rd_ptr_reg];
    assign do_push = s_valid & s_ready;
    assign do_pop = m_valid & m_ready;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= s_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

module xbc_crossbar #(
    parameter int FRAME_CYCLES = xbc_pkg::FRAME_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire xbc_pkg::xbc_ext_slots_t slot_rx,
    output xbc_pkg::xbc_ext_slots_t slot_tx,
    output logic slot_frame_strobe,
    output logic host_byte_irq
);
    import xbc_pkg::*;

    localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_CYCLES - 1);

    logic [7:0] route_reg [0:NUM_ROUTES-1];
    logic [7:0] opt_reg;
    logic [7:0] host_tx_one_reg;
    logic [7:0] host_tx_two_reg;
    logic [7:0] host_rx_one_reg;
    logic [7:0] host_rx_two_reg;
    logic avail_one_reg;
    logic avail_two_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic [FRAME_CNT_W-1:0] frame_cnt_reg;
    logic tick_reg;
    logic strobe_reg;
    xbc_ext_slots_t slot_tx_reg;

    logic [6:0] idx;
    logic req;
    logic push_valid;
    logic fifo_s_ready;
    logic [7:0] fifo_m_data;
    logic fifo_m_valid;
    logic bus_go;
    logic wr_go;
    logic rd_go;
    logic [7:0] read_mux;
    xbc_slot_vec_t src;
    xbc_slot_vec_t dest;
    logic [NUM_SLOTS:1] dest_hit;

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign host_byte_irq = irq_reg;
    assign slot_tx = slot_tx_reg;
    assign slot_frame_strobe = strobe_reg;

    // bus decode; a push into a full fifo holds the master in wait
    assign idx = avs_address[8:2];
    assign req = (avs_read | avs_write) & wait_reg;
    assign push_valid = req & avs_write & (idx == IDX_HOST_TX_ONE);
    assign bus_go = req & ~(push_valid & ~fifo_s_ready);
    assign wr_go = bus_go & avs_write;
    assign rd_go = bus_go & avs_read;

    xbc_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .s_data(avs_writedata[7:0]),
        .s_valid(push_valid & fifo_s_ready),
        .s_ready(fifo_s_ready),
        .m_data(fifo_m_data),
        .m_valid(fifo_m_valid),
        .m_ready(tick_reg)
    );

    always_comb begin
        read_mux = 8'h00;
        unique case (idx)
            IDX_ROUTE_ONE: read_mux = route_reg[0];
            IDX_ROUTE_TWO: read_mux = route_reg[1];
            IDX_ROUTE_THREE: read_mux = route_reg[2];
            IDX_SLOT_OPT: read_mux = opt_reg;
            IDX_HOST_TX_TWO: read_mux = host_tx_two_reg;
            IDX_HOST_RX_ONE: read_mux = host_rx_one_reg;
            IDX_HOST_RX_TWO: read_mux = host_rx_two_reg;
            IDX_STATUS: begin
                read_mux[ST_AVAIL_ONE] = avail_one_reg;
                read_mux[ST_AVAIL_TWO] = avail_two_reg;
                read_mux[ST_FIFO_FULL] = ~fifo_s_ready;
                read_mux[ST_FIFO_EMPTY] = ~fifo_m_valid;
                read_mux[ST_BYTE_AVAIL] = avail_one_reg | avail_two_reg;
            end
            default: read_mux = 8'h00;
        endcase
    end

    // one-cycle answer: wait drops for the edge that completes the access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= ~bus_go;
            if (rd_go) begin
                rdata_reg <= {24'h00_0000, read_mux};
            end
        end
    end

    // routing and option registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int r = 0; r < NUM_ROUTES; r++) begin
                route_reg[r] <= ROUTE_RST;
            end
            opt_reg <= OPT_RST;
            host_tx_two_reg <= IDLE_BYTE;
        end else if (wr_go) begin
            unique case (idx)
                IDX_ROUTE_ONE: route_reg[0] <= avs_writedata[7:0];
                IDX_ROUTE_TWO: route_reg[1] <= avs_writedata[7:0];
                IDX_ROUTE_THREE: route_reg[2] <= avs_writedata[7:0];
                IDX_SLOT_OPT: opt_reg <= avs_writedata[7:0] & OPT_WMASK;
                IDX_HOST_TX_TWO: host_tx_two_reg <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // frame divider: one tick per 125 us frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (frame_cnt_reg == FRAME_LAST);
            frame_cnt_reg <= (frame_cnt_reg == FRAME_LAST) ? '0 : frame_cnt_reg + 1'b1;
        end
    end

    // slot sources, host slots bit-reversed on the way out when asked
    always_comb begin
        src[CODE_B1] = slot_rx.b1;
        src[CODE_B2] = slot_rx.b2;
        src[CODE_AUDIO] = slot_rx.audio;
        src[CODE_HOST_ONE] = opt_reg[OPT_REV_ONE_BIT] ?
            xbc_rev8(host_tx_one_reg) : host_tx_one_reg;
        src[CODE_HOST_TWO] = opt_reg[OPT_REV_TWO_BIT] ?
            xbc_rev8(host_tx_two_reg) : host_tx_two_reg;
        src[CODE_PER_ONE] = slot_rx.per_one;
        src[CODE_PER_TWO] = slot_rx.per_two;
        src[CODE_PER_THREE] = slot_rx.per_three;
    end

    // later routes overwrite earlier ones, so the highest wins
    always_comb begin
        logic [3:0] a;
        logic [3:0] b;
        a = '0;
        b = '0;
        dest = '{default: IDLE_BYTE};
        dest_hit = '0;
        for (int r = 0; r < NUM_ROUTES; r++) begin
            a = route_reg[r][7:4];
            b = route_reg[r][3:0];
            if (xbc_code_ok(a) && xbc_code_ok(b)) begin
                for (int d = 1; d <= NUM_SLOTS; d++) begin
                    if (4'(d) == b) begin
                        dest[d] = src[a];
                        dest_hit[d] = 1'b1;
                    end
                    if (4'(d) == a) begin
                        dest[d] = src[b];
                        dest_hit[d] = 1'b1;
                    end
                end
            end
        end
    end

    // frame transfer onto the external slots
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_tx_reg <= '{default: IDLE_BYTE};
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= tick_reg;
            if (tick_reg) begin
                slot_tx_reg.b1 <= dest[CODE_B1];
                slot_tx_reg.b2 <= dest[CODE_B2];
                slot_tx_reg.audio <= dest[CODE_AUDIO];
                slot_tx_reg.per_one <= dest[CODE_PER_ONE];
                slot_tx_reg.per_two <= dest[CODE_PER_TWO];
                slot_tx_reg.per_three <= dest[CODE_PER_THREE];
            end
        end
    end

    // host slot one transmit byte drawn from the fifo once per frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_tx_one_reg <= IDLE_BYTE;
        end else if (tick_reg) begin
            host_tx_one_reg <= fifo_m_valid ? fifo_m_data : IDLE_BYTE;
        end
    end

    // host receive bytes and byte-available flags; a set beats a read clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_rx_one_reg <= 8'h00;
            host_rx_two_reg <= 8'h00;
            avail_one_reg <= 1'b0;
            avail_two_reg <= 1'b0;
        end else begin
            if (tick_reg && dest_hit[CODE_HOST_ONE]) begin
                host_rx_one_reg <= opt_reg[OPT_REV_ONE_BIT] ?
                    xbc_rev8(dest[CODE_HOST_ONE]) : dest[CODE_HOST_ONE];
                avail_one_reg <= 1'b1;
            end else if (rd_go && idx == IDX_HOST_RX_ONE) begin
                avail_one_reg <= 1'b0;
            end
            if (tick_reg && dest_hit[CODE_HOST_TWO]) begin
                host_rx_two_reg <= opt_reg[OPT_REV_TWO_BIT] ?
                    xbc_rev8(dest[CODE_HOST_TWO]) : dest[CODE_HOST_TWO];
                avail_two_reg <= 1'b1;
            end else if (rd_go && idx == IDX_HOST_RX_TWO) begin
                avail_two_reg <= 1'b0;
            end
        end
    end

    // byte-available interrupt, gated by the option enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (avail_one_reg | avail_two_reg) & opt_reg[OPT_IRQ_EN_BIT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_bus_answer_pulse: assert property (
        !wait_reg |=> wait_reg)
        else $error("waitrequest low for more than one cycle");

    chk_route_write_lands: assert property (
        wr_go && idx == IDX_ROUTE_THREE |=> route_reg[2] == $past(avs_writedata[7:0]))
        else $error("route three write not stored");

    chk_opt_reserved_zero: assert property (
        (opt_reg & ~OPT_WMASK) == 8'h00)
        else $error("reserved option bits not zero");

    chk_unrouted_idle: assert property (
        tick_reg && !dest_hit[CODE_B1] |=> slot_tx.b1 == IDLE_BYTE)
        else $error("unrouted slot b1 not idle");

    chk_bad_code_none: assert property (
        tick_reg && route_reg[0][7:4] > CODE_PER_THREE && route_reg[1] == 8'h00
        && route_reg[2] == 8'h00 && route_reg[0][3:0] == CODE_B2
        |=> slot_tx.b2 == IDLE_BYTE)
        else $error("illegal code moved data");

    chk_loopback_slot: assert property (
        tick_reg && route_reg[2] == {CODE_AUDIO, CODE_AUDIO}
        |=> slot_tx.audio == $past(slot_rx.audio))
        else $error("audio loopback failed");

    chk_top_priority: assert property (
        tick_reg && route_reg[2][3:0] == CODE_PER_ONE && xbc_code_ok(route_reg[2][7:4])
        |=> slot_tx.per_one == $past(src[route_reg[2][7:4]]))
        else $error("route three did not win per_one");

    chk_mid_priority: assert property (
        tick_reg && route_reg[1][3:0] == CODE_AUDIO && xbc_code_ok(route_reg[1][7:4])
        && route_reg[2][7:4] != CODE_AUDIO && route_reg[2][3:0] != CODE_AUDIO
        |=> slot_tx.audio == $past(src[route_reg[1][7:4]]))
        else $error("route two did not beat route one");

    chk_irq_masking: assert property (
        ##1 host_byte_irq == $past((avail_one_reg | avail_two_reg)
        & opt_reg[OPT_IRQ_EN_BIT]))
        else $error("interrupt not gated by enable");

    chk_rev_one_rx: assert property (
        tick_reg && dest_hit[CODE_HOST_ONE] && opt_reg[OPT_REV_ONE_BIT]
        |=> host_rx_one_reg == xbc_rev8($past(dest[CODE_HOST_ONE])) && avail_one_reg)
        else $error("host slot one not reversed");

    chk_rev_two_rx: assert property (
        tick_reg && dest_hit[CODE_HOST_TWO] && !opt_reg[OPT_REV_TWO_BIT]
        |=> host_rx_two_reg == $past(dest[CODE_HOST_TWO]) && avail_two_reg)
        else $error("host slot two reversed without request");

    chk_frame_spacing: assert property (
        tick_reg |-> frame_cnt_reg == '0 ##1 !tick_reg [*2])
        else $error("frame tick spacing wrong");

    chk_fifo_stall: assert property (
        push_valid && !fifo_s_ready |=> wait_reg)
        else $error("full fifo push was answered");

endmodule

`default_nettype wire

// file: design/xbc_pkg.sv
// package: constants, types and helpers of the slot crossbar
package xbc_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_NS = 125000;
    localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 14;

    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_SLOTS = 8;
    localparam int NUM_ROUTES = 3;

    localparam logic [6:0] IDX_ROUTE_ONE = 7'h41;
    localparam logic [6:0] IDX_ROUTE_TWO = 7'h42;
    localparam logic [6:0] IDX_ROUTE_THREE = 7'h43;
    localparam logic [6:0] IDX_SLOT_OPT = 7'h44;
    localparam logic [6:0] IDX_HOST_TX_ONE = 7'h45;
    localparam logic [6:0] IDX_HOST_TX_TWO = 7'h46;
    localparam logic [6:0] IDX_HOST_RX_ONE = 7'h47;
    localparam logic [6:0] IDX_HOST_RX_TWO = 7'h48;
    localparam logic [6:0] IDX_STATUS = 7'h49;

    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_B1 = 4'h1;
    localparam logic [3:0] CODE_B2 = 4'h2;
    localparam logic [3:0] CODE_AUDIO = 4'h3;
    localparam logic [3:0] CODE_HOST_ONE = 4'h4;
    localparam logic [3:0] CODE_HOST_TWO = 4'h5;
    localparam logic [3:0] CODE_PER_ONE = 4'h6;
    localparam logic [3:0] CODE_PER_TWO = 4'h7;
    localparam logic [3:0] CODE_PER_THREE = 4'h8;

    localparam int OPT_IRQ_EN_BIT = 3;
    localparam int OPT_REV_ONE_BIT = 4;
    localparam int OPT_REV_TWO_BIT = 5;
    localparam logic [7:0] OPT_WMASK = 8'h38;

    localparam int ST_AVAIL_ONE = 0;
    localparam int ST_AVAIL_TWO = 1;
    localparam int ST_FIFO_FULL = 2;
    localparam int ST_FIFO_EMPTY = 3;
    localparam int ST_BYTE_AVAIL = 4;

    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] audio;
        logic [7:0] per_one;
        logic [7:0] per_two;
        logic [7:0] per_three;
    } xbc_ext_slots_t;

    typedef logic [NUM_SLOTS:1][7:0] xbc_slot_vec_t;

    function automatic logic [7:0] xbc_rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    function automatic logic xbc_code_ok(input logic [3:0] c);
        return (c >= CODE_B1) && (c <= CODE_PER_THREE);
    endfunction

endpackage

// file: tb/xbc_far_model.sv
// far side model: line, audio and peripheral slots feeding the crossbar
`timescale 1ns/10ps
`default_nettype none
module xbc_far_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic slot_frame_strobe,
    output var xbc_pkg::xbc_ext_slots_t slot_rx
);
    import xbc_pkg::*;
    logic [7:0] frame_reg;
    // one fresh byte per slot each frame, held until the next strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg <= 8'h00;
        end else if (slot_frame_strobe) begin
            frame_reg <= frame_reg + 8'h01;
        end
    end
    assign slot_rx.b1 = frame_reg + 8'h10;
    assign slot_rx.b2 = frame_reg + 8'h20;
    assign slot_rx.audio = frame_reg + 8'h30;
    assign slot_rx.per_one = frame_reg + 8'h60;
    assign slot_rx.per_two = frame_reg + 8'h70;
    assign slot_rx.per_three = frame_reg + 8'h80;
endmodule
`default_nettype wire

// file: tb/tb.sv
// testbench: registers, routing table, host slots, fifo and reset
`timescale 1ns/10ps
`default_nettype none
module tb;
    import xbc_pkg::*;
    localparam int FC = 100;
    logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic slot_frame_strobe, host_byte_irq;
    logic [8:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    xbc_ext_slots_t slot_rx, slot_tx;
    int n_fail, n_checks;
    logic [7:0] rd;
    logic [7:0] src[1:8];
    logic [7:0] dst[1:8];
    // route one, two, three, options
    logic [31:0] rows[8] = '{32'h92000000, 32'h14230000, 32'h11223300, 32'h00144300,
        32'h15000020, 32'h9ff66800, 32'h67788600, 32'h51000000};

    xbc_crossbar #(.FRAME_CYCLES(FC)) xbc_crossbar_inst (.clk(clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .slot_rx(slot_rx), .slot_tx(slot_tx),
        .slot_frame_strobe(slot_frame_strobe), .host_byte_irq(host_byte_irq));
    xbc_far_model xbc_far_model_inst (.clk(clk), .arst_n(arst_n),
        .slot_frame_strobe(slot_frame_strobe), .slot_rx(slot_rx));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] v);
        rev8 = {<<{v}};
    endfunction

    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
        int k;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wd};
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (k == 300) begin
            n_fail++;
            print_verdict();
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [6:0] idx, input logic [7:0] e, input string nm);
        bus(1'b0, idx, 8'h00);
        chk8(nm, e, rd);
    endtask

    task automatic frame();
        int k;
        for (k = 0; k < 3 * FC; k++) begin
            @(posedge clk);
            if (slot_frame_strobe === 1'b1) break;
        end
        if (k == 3 * FC) begin
            n_fail++;
            print_verdict();
        end
        src[1] = slot_rx.b1;
        src[2] = slot_rx.b2;
        src[3] = slot_rx.audio;
        src[6] = slot_rx.per_one;
        src[7] = slot_rx.per_two;
        src[8] = slot_rx.per_three;
    endtask

    task automatic expect_route(input logic [31:0] r);
        logic [3:0] a, b;
        for (int i = 1; i <= 8; i++) dst[i] = 8'hff;
        for (int j = 0; j < 3; j++) begin
            a = r[31-8*j -: 4];
            b = r[27-8*j -: 4];
            if (a >= 4'h1 && a <= 4'h8 && b >= 4'h1 && b <= 4'h8) begin
                dst[a] = src[b];
                dst[b] = src[a];
            end
        end
    endtask

    task automatic cmp_tx();
        chk8("tx_b1", dst[1], slot_tx.b1);
        chk8("tx_b2", dst[2], slot_tx.b2);
        chk8("tx_audio", dst[3], slot_tx.audio);
        chk8("tx_per_one", dst[6], slot_tx.per_one);
        chk8("tx_per_two", dst[7], slot_tx.per_two);
        chk8("tx_per_three", dst[8], slot_tx.per_three);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 9'h000;
        avs_writedata = 32'h00000000;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int j = 0; j < 4; j++) rdchk(7'h41 + 7'(j), 8'h00, "ctl_reset");
        chk8("tx_idle", 8'hff, slot_tx.b1);
        rdchk(7'h10, 8'h00, "unmapped");
        bus(1'b1, 7'h46, 8'h01);
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 4; j++) bus(1'b1, 7'h41 + 7'(j), rows[i][31-8*j -: 8]);
            for (int j = 0; j < 4; j++) rdchk(7'h41 + 7'(j), rows[i][31-8*j -: 8], "ctl_rb");
            frame();
            frame();
            src[4] = 8'hff;
            src[5] = rows[i][5] ? rev8(8'h01) : 8'h01;
            expect_route(rows[i]);
            cmp_tx();
        end
        // host slot two: interrupt masked, then enabled and cleared by read
        bus(1'b1, 7'h41, 8'h15);
        bus(1'b1, 7'h44, 8'h00);
        bus(1'b0, 7'h47, 8'h00);
        frame();
        frame();
        repeat (3) @(posedge clk);
        chk1("irq_masked", 1'b0, host_byte_irq);
        rdchk(7'h48, src[1], "host_rx_two");
        bus(1'b1, 7'h44, 8'h28);
        frame();
        repeat (3) @(posedge clk);
        chk1("irq_on", 1'b1, host_byte_irq);
        chk8("tx_b1_rev", 8'h80, slot_tx.b1);
        rdchk(7'h48, rev8(src[1]), "host_rx_two_rev");
        repeat (3) @(posedge clk);
        chk1("irq_clear", 1'b0, host_byte_irq);
        rdchk(7'h49, 8'h08, "status_idle");
        // host slot one through the fifo: fill until it stalls, then drain
        bus(1'b1, 7'h44, 8'h10);
        bus(1'b1, 7'h41, 8'h14);
        frame();
        for (int i = 1; i <= 16; i++) bus(1'b1, 7'h45, 8'(i));
        rdchk(7'h49, 8'h15, "status_full");
        bus(1'b1, 7'h45, 8'h11);
        for (int k = 0; k < 4 && slot_tx.b1 !== 8'h80; k++) frame();
        chk8("host_tx_one", 8'h80, slot_tx.b1);
        for (int i = 2; i <= 17; i++) begin
            frame();
            chk8("host_tx_one", rev8(8'(i)), slot_tx.b1);
        end
        frame();
        frame();
        chk8("tx_drained", 8'hff, slot_tx.b1);
        rdchk(7'h47, rev8(src[1]), "host_rx_one_rev");
        rdchk(7'h49, 8'h08, "status_empty");
        // second reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdchk(7'h41, 8'h00, "route_after_reset");
        rdchk(7'h44, 8'h00, "opt_after_reset");
        chk8("tx_after_reset", 8'hff, slot_tx.b1);
        chk1("irq_after_reset", 1'b0, host_byte_irq);
        print_verdict();
    end
endmodule
`default_nettype wire
